// *** wdog_irq_lock.sv ***
// apb slave for watchdog raw/masked irq status, irq clear and write lock
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`include "wdog_irq_lock_cfg.svh"
module wdog_irq_lock
  import wdog_irq_lock_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`ADDR_W-1:0]   paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 timeout_event,
  input  wire logic                 irq_enable_bit,
  output logic                      irq_out,
  output logic                      irq_clear_reload,
  output logic                      write_permit
);

  irq_state_t st;
  irq_state_t next_st;
  logic       setup;
  logic       access;
  logic       lock_write;
  logic       locked;

  // true when the address equals the given register offset
  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a,
                                    input logic [`ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [`ADDR_W-1:0] a);
    mapped = addr_hit(a, `OFS_CLEAR_RELOAD) |
             addr_hit(a, `OFS_RAW_STATUS)   |
             addr_hit(a, `OFS_MASKED_STATUS) |
             addr_hit(a, `OFS_WRITE_LOCK);
  endfunction

  // bus phases; pready is our own flop so access ends after one cycle
  assign setup      = psel & ~penable;
  assign access     = psel & penable & st.pready;
  assign lock_write = access & pwrite & addr_hit(paddr, `OFS_WRITE_LOCK);

  write_guard_key u_guard (
    .pclk         (pclk),
    .presetn      (presetn),
    .lock_write   (lock_write),
    .key_data     (pwdata),
    .locked       (locked),
    .write_permit (write_permit)
  );

  // next state: bus answer, clear pulse, raw and masked flags
  always_comb begin
    next_st              = st;
    next_st.pready       = setup;
    next_st.pslverr      = setup & ~mapped(paddr);
    next_st.prdata       = `RDATA_RESET;
    // [R7] clear write
    // [R5] ignored while locked
    next_st.reload_pulse = access & pwrite & ~locked &
                           addr_hit(paddr, `OFS_CLEAR_RELOAD);
    // set wins over clear so a timeout in the clear cycle is not lost
    if (timeout_event) begin
      next_st.raw_flag = 1'b1;
    end else if (next_st.reload_pulse) begin
      next_st.raw_flag = 1'b0;
    end
    // [R3] raw AND enable
    next_st.masked_flag = next_st.raw_flag & irq_enable_bit;
    // read data captured in setup, held through the access cycle
    if (setup & ~pwrite) begin
      // [R1] raw flag bit 0
      // [R2] readable when masked
      if (addr_hit(paddr, `OFS_RAW_STATUS)) begin
        next_st.prdata[`STATUS_BIT] = st.raw_flag;
      end
      if (addr_hit(paddr, `OFS_MASKED_STATUS)) begin
        next_st.prdata[`STATUS_BIT] = st.masked_flag;
      end
      // [R6] lock status read
      if (addr_hit(paddr, `OFS_WRITE_LOCK)) begin
        next_st.prdata = locked ? `LOCK_READ_LOCKED : `LOCK_READ_UNLOCKED;
      end
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.prdata       <= `RDATA_RESET;
      st.pready       <= 1'b0;
      st.pslverr      <= 1'b0;
      st.raw_flag     <= `FLAG_RESET;
      st.masked_flag  <= `FLAG_RESET;
      st.reload_pulse <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign irq_out          = st.masked_flag;
  assign irq_clear_reload = st.reload_pulse;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // [R1] raw read data
  property p_raw_read;
    setup && !pwrite && addr_hit(paddr, `OFS_RAW_STATUS)
      |=> prdata == {31'h0, $past(st.raw_flag)};
  endproperty
  a_raw_read: assert property (p_raw_read) // [R1]
    else $error("raw status read data wrong");

  // [R2] polled while masked
  property p_poll_masked;
    timeout_event && !irq_enable_bit |=> st.raw_flag && !irq_out;
  endproperty
  a_poll_masked: assert property (p_poll_masked) // [R2]
    else $error("raw flag not set while interrupt disabled");

  // [R3] raw AND enable
  property p_masked;
    irq_out == (st.raw_flag && $past(irq_enable_bit));
  endproperty
  a_masked: assert property (p_masked) // [R3]
    else $error("masked flag not raw and enable");

  // [R4] key unlocks
  // the next lock write can land two edges later at the earliest
  property p_unlock;
    lock_write && pwdata == `UNLOCK_KEY |=> write_permit ##1 write_permit;
  endproperty
  a_unlock: assert property (p_unlock) // [R4]
    else $error("key write did not unlock");

  // [R5] other value locks
  property p_relock;
    lock_write && pwdata != `UNLOCK_KEY |=> !write_permit;
  endproperty
  a_relock: assert property (p_relock) // [R5]
    else $error("non key write did not lock");

  // [R5] locked clear ignored
  property p_locked_clear;
    access && pwrite && !write_permit &&
      addr_hit(paddr, `OFS_CLEAR_RELOAD) |=> !irq_clear_reload;
  endproperty
  a_locked_clear: assert property (p_locked_clear) // [R5]
    else $error("clear write taken while locked");

  // [R6] lock status read
  property p_lock_read;
    setup && !pwrite && addr_hit(paddr, `OFS_WRITE_LOCK)
      |=> prdata == ($past(write_permit) ? `LOCK_READ_UNLOCKED
                                         : `LOCK_READ_LOCKED);
  endproperty
  a_lock_read: assert property (p_lock_read) // [R6]
    else $error("lock register read value wrong");

  // [R7] clear and reload
  property p_clear;
    access && pwrite && write_permit && !timeout_event &&
      addr_hit(paddr, `OFS_CLEAR_RELOAD)
      |=> irq_clear_reload && !st.raw_flag ##1 !irq_clear_reload;
  endproperty
  a_clear: assert property (p_clear) // [R7]
    else $error("clear write did not clear and reload");

  // [R8] reset unlocked
  property p_reset_unlocked;
    $rose(presetn) |-> write_permit;
  endproperty
  a_reset_unlocked: assert property (p_reset_unlocked) // [R8]
    else $error("not unlocked after reset");

  // [R3] masked read data
  property p_masked_read;
    setup && !pwrite && addr_hit(paddr, `OFS_MASKED_STATUS)
      |=> prdata == {31'h0, $past(irq_out)};
  endproperty
  a_masked_read: assert property (p_masked_read) // [R3]
    else $error("masked status read data wrong");

  // [R2] timeout sets flag
  property p_raw_set;
    timeout_event |=> st.raw_flag;
  endproperty
  a_raw_set: assert property (p_raw_set) // [R2]
    else $error("timeout did not set raw flag");

  // [R7] flag falls only on clear
  property p_raw_clear_only;
    $fell(st.raw_flag) |-> irq_clear_reload;
  endproperty
  a_raw_clear_only: assert property (p_raw_clear_only) // [R7]
    else $error("raw flag fell without a clear write");

  // [R7] reload one pulse
  property p_reload_once;
    irq_clear_reload |=> !irq_clear_reload;
  endproperty
  a_reload_once: assert property (p_reload_once) // [R7]
    else $error("reload request longer than one cycle");

  // bus answer shape: one access cycle, so pready never stays high
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready high for more than one cycle");

  // an error is only meaningful while the answer stands
  property p_error_with_ready;
    pslverr |-> pready;
  endproperty
  a_error_with_ready: assert property (p_error_with_ready)
    else $error("pslverr without pready");

  // read data is zero outside the access cycle, so stale data never leaks
  property p_idle_rdata;
    !pready |-> prdata == `RDATA_RESET;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata)
    else $error("read data not zero outside access");

  // unmapped addresses answer with an error and zero data
  property p_unmapped;
    setup && !mapped(paddr) |=> pslverr && prdata == `RDATA_RESET;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

endmodule

// *** wdog_irq_lock_cfg.svh ***
// offsets, key, read values and reset values of the irq status / lock block
// What this block does
// [R1] raw status register bit 0 shows unmasked interrupt; bits 31:1 read zero
// [R2] raw flag stays readable while interrupt output is disabled
// [R3] masked status bit 0 is raw flag AND interrupt enable bit
// [R4] writing key 0x1ACCE551 to lock register permits writes elsewhere
// [R5] writing any other value locks; other register writes then ignored
// [R6] lock register reads 1 while locked, 0 while unlocked
// [R7] any unlocked write to clear register reloads counter and clears flag; a timeout in the same cycle still reloads but keeps the flag set
// [R8] after reset the block is unlocked and lock register reads zero
`ifndef WDOG_IRQ_LOCK_CFG_SVH
`define WDOG_IRQ_LOCK_CFG_SVH

`define ADDR_W             12
`define OFS_CLEAR_RELOAD   12'h00c
`define OFS_RAW_STATUS     12'h010
`define OFS_MASKED_STATUS  12'h014
`define OFS_WRITE_LOCK     12'hc00
`define UNLOCK_KEY         32'h1acce551
`define LOCK_READ_LOCKED   32'h00000001
`define LOCK_READ_UNLOCKED 32'h00000000
`define STATUS_BIT         0
`define LOCKED_RESET       1'b0
`define FLAG_RESET         1'b0
`define RDATA_RESET        32'h00000000

`endif

// *** wdog_irq_lock_pkg.sv ***
// state types of the irq status / lock block
package wdog_irq_lock_pkg;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        raw_flag;
    logic        masked_flag;
    logic        reload_pulse;
  } irq_state_t;

  typedef struct packed {
    logic locked;
    logic write_permit;
  } lock_state_t;

endpackage

// *** write_guard_key.sv ***
// lock state holder: key write unlocks, any other write locks
`timescale 1ns/100ps
`include "wdog_irq_lock_cfg.svh"
module write_guard_key
  import wdog_irq_lock_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        lock_write,
  input  wire logic [31:0] key_data,
  output logic             locked,
  output logic             write_permit
);

  lock_state_t st;
  lock_state_t next_st;

  // a completed write to the lock register decides the new state
  always_comb begin
    next_st = st;
    if (lock_write) begin
      // [R4] key unlocks
      // [R5] other value locks
      next_st.locked = (key_data != `UNLOCK_KEY);
    end
    // permit kept as its own flop so the output needs no gate
    next_st.write_permit = ~next_st.locked;
  end

  // [R8] reset unlocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.locked       <= `LOCKED_RESET;
      st.write_permit <= ~`LOCKED_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign locked       = st.locked;
  assign write_permit = st.write_permit;

endmodule

// *** tb_top.sv ***
// self-checking bench for the irq status and write lock block
`timescale 1ns/100ps
`include "wdog_irq_lock_cfg.svh"
module tb_top;
  import wdog_irq_lock_pkg::*;
  typedef struct {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } row_t;
  logic        pclk           = 1'b0;
  logic        presetn        = 1'b0;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [11:0] paddr          = 12'h000;
  logic [31:0] pwdata         = 32'h00000000;
  logic        timeout_event  = 1'b0;
  logic        irq_enable_bit = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_out;
  logic        irq_clear_reload;
  logic        write_permit;
  logic [31:0] rd;
  logic        er;
  int          err_count       = 0;
  int          samples_checked = 0;
  row_t        rows[10];

  wdog_irq_lock dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timeout_event(timeout_event), .irq_enable_bit(irq_enable_bit),
    .irq_out(irq_out), .irq_clear_reload(irq_clear_reload),
    .write_permit(write_permit));

  // 50 MHz clock
  always #10 pclk = ~pclk;

  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic chk1(input logic g, input logic x);
    chk32({31'h0, g}, {31'h0, x});
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: the wait ends on pready, or on the bench watchdog if pready never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk32(rd, x);
  endtask

  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 200 cycles
  initial begin
    #100000;
    err_count++;
    complete_run();
  end

  initial begin
    rows[0] = '{1'b0, `OFS_RAW_STATUS, 32'h0, 32'h0, 1'b0};
    rows[1] = '{1'b0, `OFS_MASKED_STATUS, 32'h0, 32'h0, 1'b0};
    rows[2] = '{1'b0, `OFS_WRITE_LOCK, 32'h0, `LOCK_READ_UNLOCKED, 1'b0};
    rows[3] = '{1'b1, `OFS_RAW_STATUS, 32'hffffffff, 32'h0, 1'b0};
    rows[4] = '{1'b0, `OFS_RAW_STATUS, 32'h0, 32'h0, 1'b0};
    rows[5] = '{1'b0, 12'h123, 32'h0, 32'h0, 1'b1};
    rows[6] = '{1'b1, `OFS_WRITE_LOCK, 32'h1acce550, 32'h0, 1'b0};
    rows[7] = '{1'b0, `OFS_WRITE_LOCK, 32'h0, `LOCK_READ_LOCKED, 1'b0};
    rows[8] = '{1'b1, `OFS_WRITE_LOCK, `UNLOCK_KEY, 32'h0, 1'b0};
    rows[9] = '{1'b0, `OFS_WRITE_LOCK, 32'h0, `LOCK_READ_UNLOCKED, 1'b0};
    @(posedge pclk);
    #1 chk1(write_permit, 1'b1);
    @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk32(rd, rows[i].x);
      chk1(er, rows[i].e);
    end
    $display("table test done");
    // raw flag visible while the interrupt output is disabled
    @(posedge pclk);
    timeout_event <= 1'b1;
    @(posedge pclk);
    timeout_event <= 1'b0;
    #1 chk1(irq_out, 1'b0);
    rdchk(`OFS_RAW_STATUS, 32'h00000001);
    rdchk(`OFS_MASKED_STATUS, 32'h00000000);
    irq_enable_bit <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk1(irq_out, 1'b1);
    rdchk(`OFS_MASKED_STATUS, 32'h00000001);
    $display("status test done");
    // clear is ignored while locked, taken once unlocked
    apb(1'b1, `OFS_WRITE_LOCK, 32'h00000000);
    #1 chk1(write_permit, 1'b0);
    apb(1'b1, `OFS_CLEAR_RELOAD, 32'h0000abcd);
    #1 chk1(irq_clear_reload, 1'b0);
    rdchk(`OFS_RAW_STATUS, 32'h00000001);
    apb(1'b1, `OFS_WRITE_LOCK, `UNLOCK_KEY);
    #1 chk1(write_permit, 1'b1);
    apb(1'b1, `OFS_CLEAR_RELOAD, 32'h00000000);
    #1 chk1(irq_clear_reload, 1'b1);
    rdchk(`OFS_RAW_STATUS, 32'h00000000);
    chk1(irq_out, 1'b0);
    $display("lock and clear test done");
    // mid-run reset while locked with the raw flag set
    @(posedge pclk);
    timeout_event <= 1'b1;
    @(posedge pclk);
    timeout_event <= 1'b0;
    apb(1'b1, `OFS_WRITE_LOCK, 32'h00000000);
    rdchk(`OFS_RAW_STATUS, 32'h00000001);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1 chk1(write_permit, 1'b1);
    chk1(irq_out, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`OFS_WRITE_LOCK, `LOCK_READ_UNLOCKED);
    rdchk(`OFS_RAW_STATUS, 32'h00000000);
    $display("reset test done");
    complete_run();
  end
endmodule
